/* hdl/lod_defs.vh */
// Constants for the logic/or/control-read decode slice.
// Assumes 32-bit instruction words and a 32-entry register file.
`ifndef LOD_DEFS_VH
`define LOD_DEFS_VH
`define LOD_OP_RTYPE      6'h3a
`define LOD_OP_ORHI       6'h34
`define LOD_OP_ORI        6'h14
`define LOD_OP_PREV_READ  6'h38
`define LOD_OPX_NEXTPC    6'h1c
`define LOD_OPX_NOR       6'h06
`define LOD_OPX_OR        6'h16
`define LOD_OPX_CTL_READ  6'h26
`define LOD_OPX_RET       6'h05
`define LOD_OPX_ADD       6'h31
`define LOD_PC_STEP       32'h0000_0004
`define LOD_HALF_ZERO     16'h0000
`define LOD_RA_INDEX      5'h1f
`define LOD_A_HI          31
`define LOD_A_LO          27
`define LOD_B_HI          26
`define LOD_B_LO          22
`define LOD_C_HI          21
`define LOD_C_LO          17
`define LOD_IMM_HI        21
`define LOD_IMM_LO        6
`define LOD_OPX_HI        16
`define LOD_OPX_LO        11
`define LOD_N_HI          10
`define LOD_N_LO          6
`define LOD_OP_HI         5
`define LOD_OP_LO         0
`define LOD_EXC_NONE      3'h0
`define LOD_EXC_SUPER     3'h1
`define LOD_EXC_ILLEGAL   3'h2
`define LOD_EXC_MISALIGN  3'h3
`define LOD_EXC_UNKNOWN   3'h4
`endif

/* hdl/lod_decoder.v */
// Decode and execute stage for nextpc, nop, nor, or, orhi, ori, control-register
// read, previous-set read and return. Assumes the pipeline presents operands
// read from the register file (current and previous set) with each instruction.
`timescale 1ns/10ps
`include "lod_defs.vh"

module lod_decoder #(
  parameter HAS_SHADOW = 1
) (
  input  wire        REF_CLK,
  input  wire        RST_N,
  input  wire        INSTR_VALID,
  input  wire [31:0] INSTR_WORD,
  input  wire [31:0] INSTR_PC,
  input  wire [31:0] RA_VALUE,
  input  wire [31:0] RB_VALUE,
  input  wire [31:0] PREV_RA_VALUE,
  input  wire [31:0] CTL_VALUE,
  input  wire [31:0] RETURN_ADDR,
  input  wire [3:0]  STATUS_PREV_SET,
  input  wire        SUPERVISOR,
  output reg  [4:0]  RA_INDEX,
  output reg  [4:0]  RB_INDEX,
  output reg  [4:0]  CTL_INDEX,
  output reg  [3:0]  PREV_SET,
  output reg         WR_EN,
  output reg  [4:0]  WR_INDEX,
  output reg  [31:0] WR_DATA,
  output reg         PC_LOAD,
  output reg  [31:0] PC_TARGET,
  output reg         EXC_VALID,
  output reg  [2:0]  EXC_CAUSE,
  output reg         DONE
);

  // Field extraction shared by operand steering and execution
  // Positions come from the shared header; nothing here is hard-wired
  function [5:0] opx_of;
    input [31:0] w;
    begin
      opx_of = w[`LOD_OPX_HI:`LOD_OPX_LO];
    end
  endfunction

  function [5:0] op_of;
    input [31:0] w;
    begin
      op_of = w[`LOD_OP_HI:`LOD_OP_LO];
    end
  endfunction

  // Register fields; the immediate overlaps C, N and the extended opcode,
  // so only the primary opcode says which reading applies
  wire [5:0]  op   = op_of(INSTR_WORD);
  wire [5:0]  opx  = opx_of(INSTR_WORD);
  wire [4:0]  fa   = INSTR_WORD[`LOD_A_HI:`LOD_A_LO];
  wire [4:0]  fb   = INSTR_WORD[`LOD_B_HI:`LOD_B_LO];
  wire [4:0]  fc   = INSTR_WORD[`LOD_C_HI:`LOD_C_LO];
  wire [4:0]  fn   = INSTR_WORD[`LOD_N_HI:`LOD_N_LO];
  wire [15:0] immediate_sixteen = INSTR_WORD[`LOD_IMM_HI:`LOD_IMM_LO];
  // Both source fields clear, which nextpc and control read insist on
  wire        ab_zero = (fa == 5'h00) && (fb == 5'h00);

  // Operand selects are registered for the register file; the pipeline
  // presents the matching values together with the word it decodes.
  // They are informational only, so their one-cycle lag is harmless;
  // reset parks them on index zero; after that the three indices follow the word and PREV_SET follows STATUS_PREV_SET on every edge, valid or not.
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      RA_INDEX  <= 5'h00;
      RB_INDEX  <= 5'h00;
      CTL_INDEX <= 5'h00;
      PREV_SET  <= 4'h0;
    end else begin
      RA_INDEX  <= fa;
      RB_INDEX  <= fb;
      CTL_INDEX <= fn;
      PREV_SET  <= STATUS_PREV_SET;
    end
  end

  // Next values of the result register, all decided in one cycle
  reg         next_wr_en;
  reg  [4:0]  next_wr_index;
  reg  [31:0] next_wr_data;
  reg         next_pc_load;
  reg  [31:0] next_pc_target;
  reg  [2:0]  next_exc;

  // Combinational execute; an exception suppresses every write-back.
  // Priority inside each branch: build option first, then privilege, then
  // the operation itself, so a trapped word never leaves a partial result.
  // Unmatched words report cause 4 and leave the register file alone.
  always @* begin
    // Defaults: no write, no jump, no trap; the index follows the C field
    next_wr_en     = 1'b0;
    next_wr_index  = fc;
    next_wr_data   = 32'h0000_0000;
    next_pc_load   = 1'b0;
    next_pc_target = 32'h0000_0000;
    next_exc       = `LOD_EXC_NONE;
    if (op == `LOD_OP_RTYPE) begin
      // Register-format words; the extended opcode picks the operation
      if (opx == `LOD_OPX_NEXTPC && ab_zero) begin
        // Only way software sees its own address; A and B must be clear
        next_wr_en   = 1'b1;
        next_wr_data = INSTR_PC + `LOD_PC_STEP;
      end else if (opx == `LOD_OPX_ADD) begin
        // Kept so the nop alias has a real encoding to land on
        next_wr_en   = 1'b1;
        next_wr_data = RA_VALUE + RB_VALUE;
      end else if (opx == `LOD_OPX_NOR) begin
        // Bitwise, so there is no carry or overflow to report
        next_wr_en   = 1'b1;
        next_wr_data = ~(RA_VALUE | RB_VALUE);
      end else if (opx == `LOD_OPX_OR) begin
        // Same operands as nor, without the final inversion
        next_wr_en   = 1'b1;
        next_wr_data = RA_VALUE | RB_VALUE;
      end else if (opx == `LOD_OPX_CTL_READ && ab_zero) begin
        // Control registers hold mode and status, hence the privilege check
        if (!SUPERVISOR) begin
          next_exc = `LOD_EXC_SUPER;
        end else begin
          // The value arrives already selected by the N field
          next_wr_en   = 1'b1;
          next_wr_data = CTL_VALUE;
        end
      end else if (opx == `LOD_OPX_RET) begin
        // Word alignment is checked before the jump is committed
        if (RETURN_ADDR[1:0] != 2'b00) begin
          next_exc = `LOD_EXC_MISALIGN;
        end else begin
          // The fetch unit takes its target from RETURN_ADDR
          next_pc_load   = 1'b1;
          next_pc_target = RETURN_ADDR;
        end
      end else begin
        // Other extended opcodes belong to other execute slices
        next_exc = `LOD_EXC_UNKNOWN;
      end
    end else if (op == `LOD_OP_ORHI) begin
      // Immediate forms write the B field, not the C field
      next_wr_en    = 1'b1;
      next_wr_index = fb;
      next_wr_data  = RA_VALUE | {immediate_sixteen, `LOD_HALF_ZERO};
    end else if (op == `LOD_OP_ORI) begin
      // Zero fill, not sign fill: this immediate is unsigned
      next_wr_en    = 1'b1;
      next_wr_index = fb;
      next_wr_data  = RA_VALUE | {`LOD_HALF_ZERO, immediate_sixteen};
    end else if (op == `LOD_OP_PREV_READ) begin
      // Target is in the current set; only the source comes from the old set
      next_wr_index = fb;
      if (HAS_SHADOW == 0) begin
        // A core with one register set has no previous set to read
        next_exc = `LOD_EXC_ILLEGAL;
      end else if (!SUPERVISOR) begin
        next_exc = `LOD_EXC_SUPER;
      end else begin
        // Signed offset, so one word can reach below its base as well
        next_wr_en   = 1'b1;
        next_wr_data = PREV_RA_VALUE + {{16{immediate_sixteen[15]}}, immediate_sixteen};
      end
    end else begin
      // Any other primary opcode is handled elsewhere in the pipeline
      next_exc = `LOD_EXC_UNKNOWN;
    end
    // Writes to register zero are dropped, which makes the nop alias harmless;
    // this also quietly covers nextpc, nor and or aimed at register zero
    if (next_wr_index == 5'h00) begin
      next_wr_en = 1'b0;
    end
  end

  // Result register; every output is a flop so timing stays local.
  // Data, index and cause load on every edge; only the strobes are gated
  // by INSTR_VALID, which keeps the enable load off the wide buses.
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      // All strobes low, so nothing is written or taken on the first edge
      WR_EN     <= 1'b0;
      WR_INDEX  <= 5'h00;
      WR_DATA   <= 32'h0000_0000;
      PC_LOAD   <= 1'b0;
      PC_TARGET <= 32'h0000_0000;
      EXC_VALID <= 1'b0;
      EXC_CAUSE <= `LOD_EXC_NONE;
      DONE      <= 1'b0;
    end else begin
      // One answer per valid word, exactly one edge after it is taken
      WR_EN     <= INSTR_VALID & next_wr_en;
      WR_INDEX  <= next_wr_index;
      WR_DATA   <= next_wr_data;
      PC_LOAD   <= INSTR_VALID & next_pc_load;
      PC_TARGET <= next_pc_target;
      EXC_VALID <= INSTR_VALID & (next_exc != `LOD_EXC_NONE);
      EXC_CAUSE <= next_exc;
      DONE      <= INSTR_VALID;
    end
  end

endmodule

/* test/lod_decoder_checker.sv */
// Checker for the decode slice: each registered answer is tied to the word
// taken one edge earlier. Assumes HAS_SHADOW follows the build it is bound to.
`timescale 1ns/10ps
module lod_decoder_checker #(
  parameter HAS_SHADOW = 1
) (
  input wire        REF_CLK,
  input wire        RST_N,
  input wire        INSTR_VALID,
  input wire [31:0] INSTR_WORD,
  input wire [31:0] INSTR_PC,
  input wire [31:0] RA_VALUE,
  input wire [31:0] RB_VALUE,
  input wire [31:0] PREV_RA_VALUE,
  input wire [31:0] CTL_VALUE,
  input wire [31:0] RETURN_ADDR,
  input wire        SUPERVISOR,
  input wire        WR_EN,
  input wire [31:0] WR_DATA,
  input wire        PC_LOAD,
  input wire [31:0] PC_TARGET,
  input wire        EXC_VALID,
  input wire [2:0]  EXC_CAUSE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Field slices of the word being taken
  wire [5:0]  x  = INSTR_WORD[16:11];
  wire [15:0] im = INSTR_WORD[21:6];
  wire        rt = INSTR_VALID && INSTR_WORD[5:0] == 6'h3a;
  wire        it = INSTR_VALID && INSTR_WORD[26:22] != 5'h00;
  wire        wc = INSTR_WORD[21:17] != 5'h00;
  wire        ret = rt && x == 6'h05 && INSTR_WORD[31:17] == 15'h7c00;
  chk_nextpc_sum: assert property (rt && x == 6'h1c && wc &&
    INSTR_WORD[31:22] == 10'h0 |=> WR_EN && WR_DATA == $past(INSTR_PC) + 32'h4)
    else $error("nextpc sum wrong");
  chk_nop_quiet: assert property (rt && x == 6'h31 && INSTR_WORD[31:17] == 15'h0 |=>
    !WR_EN && !EXC_VALID) else $error("nop changed state");
  chk_nor_value: assert property (rt && x == 6'h06 && wc |=>
    WR_EN && WR_DATA == ~($past(RA_VALUE) | $past(RB_VALUE))) else $error("nor wrong");
  chk_or_value: assert property (rt && x == 6'h16 && wc |=>
    WR_EN && WR_DATA == ($past(RA_VALUE) | $past(RB_VALUE))) else $error("or wrong");
  chk_orhi_value: assert property (it && INSTR_WORD[5:0] == 6'h34 |=>
    WR_DATA == ($past(RA_VALUE) | {$past(im), 16'h0000})) else $error("orhi wrong");
  chk_ori_value: assert property (it && INSTR_WORD[5:0] == 6'h14 |=>
    WR_DATA == ($past(RA_VALUE) | {16'h0000, $past(im)})) else $error("ori wrong");
  chk_user_trap: assert property (!SUPERVISOR &&
    (rt && x == 6'h26 && INSTR_WORD[31:22] == 10'h0 ||
    HAS_SHADOW != 0 && INSTR_VALID && INSTR_WORD[5:0] == 6'h38) |=>
    EXC_VALID && EXC_CAUSE == 3'h1 && !WR_EN) else $error("user mode read not trapped");
  chk_ctl_copy: assert property (SUPERVISOR && rt && x == 6'h26 &&
    INSTR_WORD[31:22] == 10'h0 && wc |=> WR_EN && WR_DATA == $past(CTL_VALUE))
    else $error("control read wrong");
  chk_prev_sum: assert property (HAS_SHADOW != 0 && SUPERVISOR && it &&
    INSTR_WORD[5:0] == 6'h38 |=> WR_EN && WR_DATA == $past(PREV_RA_VALUE) +
    {{16{$past(im[15])}}, $past(im)}) else $error("previous-set sum wrong");
  chk_bare_illegal: assert property (HAS_SHADOW == 0 && INSTR_VALID &&
    INSTR_WORD[5:0] == 6'h38 |=> EXC_VALID && EXC_CAUSE == 3'h2 && !WR_EN)
    else $error("previous-set read not illegal");
  chk_ret_target: assert property (ret && RETURN_ADDR[1:0] == 2'h0 |=>
    PC_LOAD && PC_TARGET == $past(RETURN_ADDR)) else $error("return target wrong");
  chk_ret_misalign: assert property (ret && RETURN_ADDR[1:0] != 2'h0 |=>
    EXC_VALID && EXC_CAUSE == 3'h3 && !PC_LOAD) else $error("misaligned return taken");
  // Main scenarios reached
  cover property (ret ##1 PC_LOAD);
  cover property (EXC_VALID && EXC_CAUSE == 3'h1);
  cover property (WR_EN ##2 WR_EN);
  cover property (EXC_VALID && EXC_CAUSE == 3'h3);
endmodule
bind lod_decoder lod_decoder_checker #(.HAS_SHADOW(HAS_SHADOW)) chk_u (.*);

/* test/lod_decoder_tb.sv */
// Self-checking bench for the decode slice, one task per instruction group.
// Assumes builds with and without shadow sets can share one stimulus.
`timescale 1ns/10ps
module lod_decoder_tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         iv = 1'b0;
  reg         sup = 1'b1;
  reg  [31:0] iw = 32'h0, ipc = 32'h0, x = 32'h0, y = 32'h0;
  wire [4:0]  ai, bi, ni, wi;
  wire [3:0]  pset;
  wire        we, pl, ev, dn;
  wire [31:0] wd, pt;
  wire [2:0]  ec;
  integer     fails = 0, checked = 0;
  // One nibble per flag: write, pc load, exception, cause, done
  wire [31:0] st = {12'h0, 3'h0, we, 3'h0, pl, 3'h0, ev, 1'b0, ec, 3'h0, dn};
  always #5 clk = ~clk;
  // Previous-set rA differs from rB so a wrong source shows up
  lod_decoder dut_u (.REF_CLK(clk), .RST_N(rst_n), .INSTR_VALID(iv), .INSTR_WORD(iw),
    .INSTR_PC(ipc), .RA_VALUE(x), .RB_VALUE(y), .PREV_RA_VALUE(y + 32'h100),
    .CTL_VALUE(~x), .RETURN_ADDR(x), .STATUS_PREV_SET(x[3:0]), .SUPERVISOR(sup),
    .RA_INDEX(ai), .RB_INDEX(bi), .CTL_INDEX(ni), .PREV_SET(pset), .WR_EN(we),
    .WR_INDEX(wi), .WR_DATA(wd), .PC_LOAD(pl), .PC_TARGET(pt), .EXC_VALID(ev),
    .EXC_CAUSE(ec), .DONE(dn));
  // Build without shadow sets on the same stimulus, for the illegal case
  wire        bare_we, bare_ev;
  wire [2:0]  bare_ec;
  lod_decoder #(.HAS_SHADOW(0)) dut_bare_u (.REF_CLK(clk), .RST_N(rst_n), .INSTR_VALID(iv),
    .INSTR_WORD(iw), .INSTR_PC(ipc), .RA_VALUE(x), .RB_VALUE(y), .PREV_RA_VALUE(y + 32'h100),
    .CTL_VALUE(~x), .RETURN_ADDR(x), .STATUS_PREV_SET(x[3:0]), .SUPERVISOR(sup),
    .RA_INDEX(), .RB_INDEX(), .CTL_INDEX(), .PREV_SET(), .WR_EN(bare_we), .WR_INDEX(),
    .WR_DATA(), .PC_LOAD(), .PC_TARGET(), .EXC_VALID(bare_ev), .EXC_CAUSE(bare_ec),
    .DONE());
  task ck(input [31:0] g, input [31:0] e);
    checked = checked + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Present one word for one cycle, then look after the answering edge
  task issue(input [31:0] w, input [31:0] a, input [31:0] b, input s);
    @(posedge clk);
    iw <= w;
    x <= a;
    y <= b;
    sup <= s;
    ipc <= ipc + 32'h4;
    iv <= 1'b1;
    @(posedge clk);
    iv <= 1'b0;
    #1;
  endtask
  task t_basic;
    issue(32'h000ce03a, 32'h12345678, 32'h0, 1'b0);
    ck(st, 32'h00010001);
    ck(wd, ipc + 32'h4);
    ck({27'h0, wi}, 32'h6);
    issue(32'h0001883a, 32'hffffffff, 32'hffffffff, 1'b0);
    ck(st, 32'h00000001);
  endtask
  task t_logic;
    issue(32'h3a0c303a, 32'hf0f00000, 32'h000000ff, 1'b0);
    ck(wd, 32'h0f0fff00);
    ck(st, 32'h00010001);
    ck({27'h0, ai}, 32'h7);
    ck({27'h0, bi}, 32'h8);
    issue(32'h3a0cb03a, 32'hf0f00000, 32'h000000ff, 1'b0);
    ck(wd, 32'hf0f000ff);
  endtask
  task t_imm;
    issue(32'h3a600074, 32'h00001234, 32'h0, 1'b0);
    ck(wd, 32'h80011234);
    ck({27'h0, wi}, 32'h9);
    issue(32'h3a600054, 32'h00001234, 32'h0, 1'b0);
    ck(wd, 32'h00009235);
  endtask
  task t_priv;
    issue(32'h000737fa, 32'ha5a50000, 32'h0, 1'b1);
    ck(wd, 32'h5a5affff);
    ck({27'h0, wi}, 32'h3);
    ck({27'h0, ni}, 32'h1f);
    issue(32'h000737fa, 32'ha5a50000, 32'h0, 1'b0);
    ck(st, 32'h00000111);
    issue(32'h39bffff8, 32'h00000007, 32'h00000010, 1'b1);
    ck(wd, 32'h0000010f);
    ck({28'h0, pset}, 32'h7);
    ck({27'h0, bare_we, bare_ev, bare_ec}, 32'h0000000a);
    issue(32'h39bffff8, 32'h00000007, 32'h00000010, 1'b0);
    ck(st, 32'h00000111);
    ck({27'h0, bare_we, bare_ev, bare_ec}, 32'h0000000a);
  endtask
  task t_ret;
    integer i;
    issue(32'hf800283a, 32'h00002000, 32'h0, 1'b0);
    ck(st, 32'h00001001);
    ck(pt, 32'h00002000);
    // Both low address bits on their own must trap
    for (i = 1; i < 4; i = i + 1) begin
      issue(32'hf800283a, 32'h00002000 + i, 32'h0, 1'b1);
      ck(st, 32'h00000131);
    end
  endtask
  task complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_basic;
    t_logic;
    t_imm;
    t_priv;
    t_ret;
    complete_run;
  end
  // About forty cycles of work; cut off well beyond that
  initial begin
    #20000;
    fails = fails + 1;
    complete_run;
  end
endmodule
